// ### rtl/hmdp_device.sv
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
// What this block does
// RULE1: host reaches program and data memory, one cycle
// RULE2: host writes never reach control registers
// RULE3: host checks acknowledge before latch or access
// RULE4: top bit set: low byte selects overlay
// RULE5: top bit clear: address and memory space
// RULE6: one 16-bit shared bus, 24-bit words
// RULE7: host strobes free of processor timing
// RULE8: address increments after each completed transfer
// RULE9: host drives address and space after acknowledge
// RULE10: latch captured on latch falling edge with select
// RULE11: select plus read or write requests transfer
// RULE12: one cycle synchronise, one cycle memory access
// RULE13: processor can write start-address control register
// RULE14: control register sits at data address 0x3FE0
// RULE15: host cannot read back latched start address
// RULE16: host waits acknowledge before transfer is complete
// RULE17: program word moves as two transfers
// RULE18: drive-select low: acknowledge actively driven
// RULE19: drive-select high: acknowledge open-source only
// RULE20: host memory mode strap sampled at reset
// RULE21: host boot holds execution until word zero
module hmdp_device (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rstn,
  // link to the host
  hmdp_if.dev                                 p,
  // configuration straps
  input  wire logic                           mode_host_strap,
  input  wire logic                           mode_port_boot_strap,
  input  wire logic                           ack_drive_strap,
  // processor access to the start-address control register
  input  wire logic                           cpu_we,
  input  wire logic [hmdp_pkg::HMDP_ADDR_W-1:0] cpu_addr,
  input  wire logic [hmdp_pkg::HMDP_DATA_W-1:0] cpu_wdata,
  output logic      [hmdp_pkg::HMDP_DATA_W-1:0] cpu_rdata,
  // on-chip memory port, one stolen cycle per access
  output logic                                mem_req,
  output logic                                mem_we,
  output logic                                mem_pm,
  output logic      [hmdp_pkg::HMDP_ADDR_W-1:0] mem_addr,
  output logic      [hmdp_pkg::HMDP_PM_W-1:0]   mem_wdata,
  input  wire logic [hmdp_pkg::HMDP_PM_W-1:0]   mem_rdata,
  output logic      [hmdp_pkg::HMDP_OVL_W-1:0]  mem_overlay,
  // status
  output logic                                host_mode,
  output logic                                exec_hold
);
  import hmdp_pkg::*;

  typedef enum logic [3:0] {
    D_IDLE   = 4'b0001,
    D_SYNC   = 4'b0010,
    D_ACCESS = 4'b0100,
    D_DONE   = 4'b1000
  } hmdp_dstate_e;

  hmdp_dstate_e             state_q;
  logic                     strap_taken_q;
  logic                     host_mode_q;
  logic                     ack_open_q;
  logic                     boot_q;
  logic                     lat_prev_q;
  logic [HMDP_DATA_W-1:0]   lat_word_q;
  logic [HMDP_ADDR_W-1:0]   addr_q;
  logic                     pm_q;
  logic                     half_q;
  logic [HMDP_OVL_W-1:0]    ovl_q;
  logic                     rd_q;
  logic [HMDP_DATA_W-1:0]   hi_hold_q;
  logic [HMDP_LOW_W-1:0]    lo_hold_q;
  logic [HMDP_DATA_W-1:0]   rdout_q;
  logic                     mem_req_q;
  logic                     mem_we_q;
  logic                     mem_pm_q;
  logic [HMDP_ADDR_W-1:0]   mem_addr_q;
  logic [HMDP_PM_W-1:0]     mem_wdata_q;
  logic                     hold_q;
  logic                     req;
  logic                     lat_fall;
  logic                     ack_active;
  logic                     need_mem;
  logic                     cpu_hit;

  ////////////////////////////////////////////////////////////////////////////
  // straps, caught on the first edge after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strap_taken_q <= 1'b0;
      host_mode_q   <= 1'b0;
      ack_open_q    <= 1'b0;
      boot_q        <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      host_mode_q   <= mode_host_strap; // RULE20
      ack_open_q    <= ack_drive_strap;
      boot_q        <= mode_port_boot_strap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // request decode; pins arrive already in this clock domain
  assign req = host_mode_q && !p.host_port_select_n &&
               (!p.host_read_strobe_n || !p.host_write_strobe_n); // RULE11
  assign lat_fall = host_mode_q && lat_prev_q && !p.host_address_latch &&
                    !p.host_port_select_n; // RULE10
  assign cpu_hit = cpu_we && (cpu_addr == HMDP_START_REG_ADDR); // RULE14

  // a program word costs memory only on the read's first half and the
  // write's second half; control registers are never written
  always_comb begin
    if (pm_q) begin
      need_mem = half_q ? !rd_q : rd_q; // RULE17
    end else begin
      need_mem = rd_q || (addr_q < HMDP_CTRL_BASE); // RULE2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer sequencing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= D_IDLE;
      rd_q    <= 1'b0;
    end else begin
      case (state_q)
        D_IDLE: begin
          if (req) begin
            state_q <= D_SYNC; // RULE12
            rd_q    <= !p.host_read_strobe_n;
          end
        end
        D_SYNC:   state_q <= D_ACCESS; // RULE12
        D_ACCESS: state_q <= D_DONE;
        D_DONE: begin
          // wait for the host to drop its strobes before rearming
          if (p.host_read_strobe_n && p.host_write_strobe_n) begin
            state_q <= D_IDLE;
          end
        end
        default:  state_q <= D_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // address-latch capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lat_prev_q <= 1'b0;
      lat_word_q <= '0;
    end else begin
      lat_prev_q <= p.host_address_latch; // RULE7
      if (p.host_address_latch && !p.host_port_select_n) begin
        lat_word_q <= p.host_addr_data_bus;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start address, memory space, half-word phase and overlay
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_q <= '0;
      pm_q   <= 1'b0;
      half_q <= 1'b0;
      ovl_q  <= '0;
    end else if (lat_fall) begin
      if (lat_word_q[HMDP_OVL_SEL_BIT]) begin
        ovl_q <= lat_word_q[HMDP_OVL_W-1:0]; // RULE4
      end else begin
        addr_q <= lat_word_q[HMDP_ADDR_W-1:0]; // RULE5
        pm_q   <= lat_word_q[HMDP_SPACE_BIT];
        half_q <= 1'b0;
      end
    end else if (state_q == D_ACCESS) begin
      if (pm_q) begin
        half_q <= !half_q;
        if (half_q) begin
          addr_q <= addr_q + HMDP_ADDR_ONE; // RULE17
        end
      end else begin
        addr_q <= addr_q + HMDP_ADDR_ONE; // RULE8
      end
    end else if (cpu_hit) begin
      // host latch wins a same-cycle clash with the processor
      addr_q <= cpu_wdata[HMDP_ADDR_W-1:0]; // RULE13
      pm_q   <= cpu_wdata[HMDP_SPACE_BIT];
      half_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // memory port and data holding
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mem_req_q   <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_pm_q    <= 1'b0;
      mem_addr_q  <= '0;
      mem_wdata_q <= '0;
      hi_hold_q   <= '0;
      lo_hold_q   <= '0;
      rdout_q     <= '0;
    end else if (state_q == D_SYNC) begin
      mem_req_q  <= need_mem; // RULE1
      mem_we_q   <= !rd_q;
      mem_pm_q   <= pm_q;
      mem_addr_q <= addr_q;
      if (pm_q) begin
        mem_wdata_q <= {hi_hold_q, p.host_addr_data_bus[HMDP_LOW_W-1:0]};
        if (!rd_q && !half_q) begin
          hi_hold_q <= p.host_addr_data_bus; // RULE6
        end
      end else begin
        mem_wdata_q <= {{HMDP_LOW_W{1'b0}}, p.host_addr_data_bus};
      end
    end else if (state_q == D_ACCESS) begin
      mem_req_q <= 1'b0;
      if (rd_q) begin
        if (!pm_q) begin
          rdout_q <= mem_rdata[HMDP_DATA_W-1:0];
        end else if (!half_q) begin
          rdout_q   <= mem_rdata[HMDP_PM_W-1:HMDP_LOW_W]; // RULE6
          lo_hold_q <= mem_rdata[HMDP_LOW_W-1:0];
        end else begin
          rdout_q <= {{HMDP_LOW_W{1'b0}}, lo_hold_q};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // boot hold-off until program word zero is written
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= 1'b1;
    end else if (!strap_taken_q) begin
      hold_q <= mode_host_strap && mode_port_boot_strap;
    end else if (mem_req_q && mem_we_q && mem_pm_q &&
                 (mem_addr_q == HMDP_BOOT_ADDR)) begin
      hold_q <= 1'b0; // RULE21
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  // acknowledge stays asserted while idle or after completion; a host that
  // polls must first see it drop to know its request was taken
  assign ack_active = (state_q == D_IDLE) || (state_q == D_DONE);

  always_comb begin
    if (ack_open_q) begin
      p.ack_out = 1'b1; // RULE19
      p.ack_oe  = host_mode_q && !ack_active;
    end else begin
      p.ack_out = !ack_active; // RULE18
      p.ack_oe  = host_mode_q;
    end
  end

  // only read data ever leaves on the bus, never the start address
  assign p.dev_bus_out = rdout_q; // RULE15
  assign p.dev_bus_oe  = (state_q == D_DONE) && rd_q &&
                         !p.host_port_select_n && !p.host_read_strobe_n;

  assign cpu_rdata   = {1'b0, pm_q, addr_q};
  assign mem_req     = mem_req_q;
  assign mem_we      = mem_we_q;
  assign mem_pm      = mem_pm_q;
  assign mem_addr    = mem_addr_q;
  assign mem_wdata   = mem_wdata_q;
  assign mem_overlay = ovl_q;
  assign host_mode   = host_mode_q;
  assign exec_hold   = hold_q && strap_taken_q && boot_q;
endmodule

// ### rtl/hmdp_host.sv
`timescale 1ns/1ps
module hmdp_host (
  // clock and reset
  input  wire logic                              clk,
  input  wire logic                              rstn,
  // Avalon-MM slave
  input  wire logic [hmdp_pkg::HMDP_AV_ADDR_W-1:0] avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [31:0]                       avs_writedata,
  output logic      [31:0]                       avs_readdata,
  output logic                                   avs_waitrequest,
  // link to the device
  hmdp_if.host                                   p
);
  import hmdp_pkg::*;

  typedef enum logic [6:0] {
    H_IDLE      = 7'b0000001,
    H_READY     = 7'b0000010,
    H_LATCH     = 7'b0000100,
    H_LATCH_END = 7'b0001000,
    H_WAIT_BUSY = 7'b0010000,
    H_WAIT_DONE = 7'b0100000,
    H_UNUSED    = 7'b1000000
  } hmdp_hstate_e;

  hmdp_hstate_e           state_q;
  hmdp_op_e               op_q;
  logic [HMDP_DATA_W-1:0] word_q;
  logic [HMDP_DATA_W-1:0] rdata_q;
  logic                   sel_n_q;
  logic                   latch_q;
  logic                   rd_n_q;
  logic                   wr_n_q;
  logic                   oe_q;
  logic [HMDP_DATA_W-1:0] bus_q;
  logic                   cmd_hit;
  logic                   take;
  logic [HMDP_DATA_W-1:0] lat_word;

  ////////////////////////////////////////////////////////////////////////////
  // register slave; a command write stalls until the link is idle
  assign cmd_hit = avs_write && (avs_address == HMDP_AV_CMD);
  assign take    = cmd_hit && (state_q == H_IDLE);
  assign avs_waitrequest = cmd_hit && (state_q != H_IDLE);

  always_comb begin
    if (avs_read && (avs_address == HMDP_AV_STATUS)) begin
      avs_readdata = {31'h0, state_q != H_IDLE};
    end else if (avs_read && (avs_address == HMDP_AV_RDATA)) begin
      avs_readdata = {16'h0, rdata_q};
    end else begin
      avs_readdata = 32'h0;
    end
  end

  // overlay words must carry zeros between the flag and the low byte
  always_comb begin
    lat_word = word_q;
    if (word_q[HMDP_OVL_SEL_BIT]) begin
      lat_word[HMDP_OVL_ZERO_HI:HMDP_OVL_ZERO_LO] = '0; // RULE4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link sequencing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= H_IDLE;
      op_q    <= HMDP_OP_NONE;
      word_q  <= '0;
      rdata_q <= '0;
      sel_n_q <= 1'b1;
      latch_q <= 1'b0;
      rd_n_q  <= 1'b1;
      wr_n_q  <= 1'b1;
      oe_q    <= 1'b0;
      bus_q   <= '0;
    end else begin
      case (state_q)
        H_IDLE: begin
          if (take) begin
            op_q    <= hmdp_op_e'(
                         avs_writedata[HMDP_CMD_OP_HI:HMDP_CMD_OP_LO]);
            word_q  <= avs_writedata[HMDP_DATA_W-1:0];
            state_q <= H_READY;
          end
        end
        H_READY: begin
          if (!p.host_access_ack_n) begin // RULE3
            case (op_q)
              HMDP_OP_LATCH: begin
                sel_n_q <= 1'b0;
                latch_q <= 1'b1;
                bus_q   <= lat_word; // RULE9
                oe_q    <= 1'b1;
                state_q <= H_LATCH;
              end
              HMDP_OP_WRITE: begin
                // program words go as two writes, high part first
                sel_n_q <= 1'b0; // RULE11
                wr_n_q  <= 1'b0;
                bus_q   <= word_q; // RULE17
                oe_q    <= 1'b1;
                state_q <= H_WAIT_BUSY;
              end
              HMDP_OP_READ: begin
                sel_n_q <= 1'b0; // RULE11
                rd_n_q  <= 1'b0;
                state_q <= H_WAIT_BUSY;
              end
              default: state_q <= H_IDLE;
            endcase
          end
        end
        H_LATCH: begin
          latch_q <= 1'b0;
          state_q <= H_LATCH_END;
        end
        H_LATCH_END: begin
          sel_n_q <= 1'b1;
          oe_q    <= 1'b0;
          state_q <= H_IDLE;
        end
        H_WAIT_BUSY: begin
          if (p.host_access_ack_n) begin
            state_q <= H_WAIT_DONE;
          end
        end
        H_WAIT_DONE: begin
          if (!p.host_access_ack_n) begin // RULE16
            if (op_q == HMDP_OP_READ) begin
              rdata_q <= p.host_addr_data_bus;
            end
            sel_n_q <= 1'b1;
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
            oe_q    <= 1'b0;
            state_q <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  assign p.host_port_select_n  = sel_n_q;
  assign p.host_address_latch  = latch_q;
  assign p.host_read_strobe_n  = rd_n_q;
  assign p.host_write_strobe_n = wr_n_q;
  assign p.host_bus_out        = bus_q;
  assign p.host_bus_oe         = oe_q;
endmodule

// ### rtl/hmdp_if.sv
`timescale 1ns/1ps
interface hmdp_if;
  import hmdp_pkg::*;
  // strobes driven by the host, select and read/write strobes active low, latch active high
  logic                   host_port_select_n;
  logic                   host_address_latch;
  logic                   host_read_strobe_n;
  logic                   host_write_strobe_n;
  // shared address/data bus, one driver set per end
  logic [HMDP_DATA_W-1:0] host_bus_out;
  logic                   host_bus_oe;
  logic [HMDP_DATA_W-1:0] dev_bus_out;
  logic                   dev_bus_oe;
  logic [HMDP_DATA_W-1:0] host_addr_data_bus;
  // acknowledge, active low, external pull-down when nobody drives
  logic                   ack_out;
  logic                   ack_oe;
  logic                   host_access_ack_n;

  assign host_addr_data_bus = host_bus_oe ? host_bus_out
                            : dev_bus_oe  ? dev_bus_out : '0;
  assign host_access_ack_n  = ack_oe ? ack_out : 1'b0;

  modport host (
    output host_port_select_n, host_address_latch,
    output host_read_strobe_n, host_write_strobe_n,
    output host_bus_out, host_bus_oe,
    input  host_addr_data_bus, host_access_ack_n
  );
  modport dev (
    input  host_port_select_n, host_address_latch,
    input  host_read_strobe_n, host_write_strobe_n,
    input  host_addr_data_bus,
    output dev_bus_out, dev_bus_oe, ack_out, ack_oe
  );
endinterface

// ### rtl/hmdp_pkg.sv
package hmdp_pkg;
  // shared bus and word widths
  localparam int HMDP_DATA_W = 16;
  localparam int HMDP_ADDR_W = 14;
  localparam int HMDP_PM_W   = 24;
  localparam int HMDP_OVL_W  = 8;
  localparam int HMDP_LOW_W  = HMDP_PM_W - HMDP_DATA_W;

  // address-latch word layout
  localparam int HMDP_OVL_SEL_BIT = 15;
  localparam int HMDP_SPACE_BIT   = 14;
  localparam int HMDP_OVL_ZERO_HI = 14;
  localparam int HMDP_OVL_ZERO_LO = 8;

  // start-address control register in data memory space
  localparam logic [13:0] HMDP_START_REG_ADDR = 14'h3FE0;
  // first data memory word of the memory-mapped control registers
  localparam logic [13:0] HMDP_CTRL_BASE      = 14'h3FE0;
  localparam logic [13:0] HMDP_BOOT_ADDR      = 14'h0000;
  localparam logic [13:0] HMDP_ADDR_ONE       = 14'h0001;

  // host controller register map, byte offsets on the Avalon-MM side
  localparam int          HMDP_AV_ADDR_W  = 4;
  localparam logic [3:0]  HMDP_AV_CMD     = 4'h0;
  localparam logic [3:0]  HMDP_AV_STATUS  = 4'h4;
  localparam logic [3:0]  HMDP_AV_RDATA   = 4'h8;
  localparam int          HMDP_CMD_OP_LO  = 16;
  localparam int          HMDP_CMD_OP_HI  = 17;

  typedef enum logic [1:0] {
    HMDP_OP_NONE  = 2'h0,
    HMDP_OP_LATCH = 2'h1,
    HMDP_OP_WRITE = 2'h2,
    HMDP_OP_READ  = 2'h3
  } hmdp_op_e;
endpackage

// ### verif/hmdp_chk.sv
`timescale 1ns/1ps
module hmdp_chk (
  // clock and reset
  input wire logic                             clk,
  input wire logic                             rstn,
  // host strobes
  input wire logic                             host_port_select_n,
  input wire logic                             host_address_latch,
  input wire logic                             host_read_strobe_n,
  input wire logic                             host_write_strobe_n,
  // shared bus drivers
  input wire logic                             host_bus_oe,
  input wire logic                             dev_bus_oe,
  input wire logic [hmdp_pkg::HMDP_DATA_W-1:0] host_addr_data_bus,
  // acknowledge
  input wire logic                             host_access_ack_n
);
  import hmdp_pkg::*;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////
  // device side: a fresh request costs one sync and one access cycle
  chk_req_sync_cost: assert property (
    (!host_port_select_n && !(host_read_strobe_n && host_write_strobe_n)
     && $past(host_read_strobe_n) && $past(host_write_strobe_n)
     && !host_access_ack_n)
    |=> host_access_ack_n [*2] ##1 !host_access_ack_n)
    else $error("acknowledge timing wrong after a request");

  chk_done_read_data: assert property (
    (!host_access_ack_n && $past(host_access_ack_n) && !host_port_select_n
     && !host_read_strobe_n) |-> dev_bus_oe)
    else $error("device not driving read data on completion");

  // the device never drives the bus outside a selected read
  chk_dev_bus_quiet: assert property (
    dev_bus_oe |-> (!host_port_select_n && !host_read_strobe_n))
    else $error("device drives the bus outside a read");

  chk_bus_one_driver: assert property (
    !(dev_bus_oe && host_bus_oe))
    else $error("both ends drive the shared bus");

  ////////////////////////////////////////////////////////////////////////////
  // host side
  chk_strobe_excl: assert property (
    !(!host_read_strobe_n && !host_write_strobe_n))
    else $error("read and write strobes low together");

  chk_host_waits_ack: assert property (
    ($fell(host_read_strobe_n) || $fell(host_write_strobe_n))
    |-> (!host_access_ack_n && !host_port_select_n))
    else $error("host started an access while busy");

  // released exactly one edge after the busy phase ended
  chk_host_holds_req: assert property (
    ($rose(host_read_strobe_n) || $rose(host_write_strobe_n))
    |-> (!$past(host_access_ack_n) && $past(host_access_ack_n, 2)))
    else $error("host released a strobe before completion");

  chk_latch_sel_fall: assert property (
    $fell(host_address_latch)
    |-> (!host_port_select_n && host_read_strobe_n && host_write_strobe_n))
    else $error("latch fell without select");

  chk_latch_bus_drv: assert property (
    host_address_latch |-> (host_bus_oe && !host_port_select_n))
    else $error("latch phase without the host driving the bus");

  chk_ovl_zero_bits: assert property (
    (host_address_latch && host_addr_data_bus[HMDP_OVL_SEL_BIT])
    |-> (host_addr_data_bus[HMDP_OVL_ZERO_HI:HMDP_OVL_ZERO_LO] == '0))
    else $error("overlay latch word has nonzero middle bits");
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import hmdp_pkg::*;
  logic        clk;
  logic        rstn;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        s_host;
  logic        s_boot;
  logic        s_drive;
  logic        cpu_we;
  logic [13:0] cpu_addr;
  logic [15:0] cpu_wdata;
  logic [15:0] cpu_rdata;
  logic        mem_req;
  logic        mem_we;
  logic        mem_pm;
  logic [13:0] mem_addr;
  logic [23:0] mem_wdata;
  logic [23:0] mem_rdata;
  logic [7:0]  mem_overlay;
  logic        host_mode;
  logic        exec_hold;
  logic [23:0] pm [0:16383];
  logic [15:0] dm [0:16383];
  int          error_cnt;
  int          checked;
  int          req_cnt = 0;

  hmdp_if link ();

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // behavioural on-chip memory; read data valid while mem_req is high
  assign mem_rdata = mem_pm ? pm[mem_addr] : {8'h00, dm[mem_addr]};
  always @(posedge clk) begin
    if (mem_req) begin
      req_cnt <= req_cnt + 1;
      if (mem_we && mem_pm) pm[mem_addr] <= mem_wdata;
      if (mem_we && !mem_pm) dm[mem_addr] <= mem_wdata[15:0];
    end
  end

  hmdp_host i_hmdp_host (.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .p(link));
  hmdp_device i_hmdp_device (.clk(clk), .rstn(rstn), .p(link),
    .mode_host_strap(s_host), .mode_port_boot_strap(s_boot),
    .ack_drive_strap(s_drive), .cpu_we(cpu_we), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .mem_req(mem_req),
    .mem_we(mem_we), .mem_pm(mem_pm), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_overlay(mem_overlay),
    .host_mode(host_mode), .exec_hold(exec_hold));
  hmdp_chk i_hmdp_chk (.clk(clk), .rstn(rstn),
    .host_port_select_n(link.host_port_select_n),
    .host_address_latch(link.host_address_latch),
    .host_read_strobe_n(link.host_read_strobe_n),
    .host_write_strobe_n(link.host_write_strobe_n),
    .host_bus_oe(link.host_bus_oe), .dev_bus_oe(link.dev_bus_oe),
    .host_addr_data_bus(link.host_addr_data_bus),
    .host_access_ack_n(link.host_access_ack_n));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // one Avalon cycle, held until waitrequest is seen low at an edge
  task automatic av(input logic rd, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= rd;
    avs_write     <= !rd;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic op(input hmdp_op_e o, input logic [15:0] w);
    logic [31:0] q;
    av(1'b0, HMDP_AV_CMD, {14'h0000, o, w}, q);
    do begin
      av(1'b1, HMDP_AV_STATUS, 32'h0000_0000, q);
    end while (q[0] !== 1'b0);
  endtask

  task automatic hrd(output logic [15:0] d);
    logic [31:0] q;
    op(HMDP_OP_READ, 16'h0000);
    av(1'b1, HMDP_AV_RDATA, 32'h0000_0000, q);
    d = q[15:0];
  endtask

  task automatic cpu_w(input logic [13:0] a, input logic [15:0] d);
    @(posedge clk);
    cpu_we    <= 1'b1;
    cpu_addr  <= a;
    cpu_wdata <= d;
    @(posedge clk);
    cpu_we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic do_reset(input logic h, input logic b, input logic dr);
    @(posedge clk);
    rstn    <= 1'b0;
    s_host  <= h;
    s_boot  <= b;
    s_drive <= dr;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic t_boot();
    logic [15:0] d;
    chk("host_mode", 1, host_mode);
    chk("ack_oe", 1, link.ack_oe);
    chk("ack_out", 0, link.ack_out);
    chk("exec_hold", 1, exec_hold);
    op(HMDP_OP_LATCH, 16'h4001);
    op(HMDP_OP_WRITE, 16'h0102);
    op(HMDP_OP_WRITE, 16'h0003);
    op(HMDP_OP_LATCH, 16'h4000);
    op(HMDP_OP_WRITE, 16'hA1B2);
    chk("exec_hold", 1, exec_hold);
    op(HMDP_OP_WRITE, 16'h00C3);
    chk("exec_hold", 0, exec_hold);
    chk("pm0", 24'hA1B2C3, pm[0]);
    chk("pm1", 24'h010203, pm[1]);
    op(HMDP_OP_LATCH, 16'h4000);
    hrd(d);
    chk("pm rd hi", 16'hA1B2, d);
    hrd(d);
    chk("pm rd lo", 16'h00C3, d);
    hrd(d);
    chk("pm rd next", 16'h0102, d);
  endtask

  task automatic t_dm();
    logic [15:0] w [3];
    logic [15:0] d;
    int c;
    w = '{16'hFFFF, 16'h0000, 16'hA55A};
    op(HMDP_OP_LATCH, 16'h0100);
    c = req_cnt;
    for (int i = 0; i < 3; i++) op(HMDP_OP_WRITE, w[i]);
    chk("mem cycles", 3, req_cnt - c);
    for (int i = 0; i < 3; i++) chk("dm", w[i], dm[256 + i]);
    op(HMDP_OP_LATCH, 16'h0100);
    for (int i = 0; i < 3; i++) begin
      hrd(d);
      chk("dm rd", w[i], d);
    end
  endtask

  // writes into the control block are dropped but still advance the address
  task automatic t_ctrl();
    op(HMDP_OP_LATCH, 16'h3FDF);
    op(HMDP_OP_WRITE, 16'h1111);
    op(HMDP_OP_WRITE, 16'h2222);
    op(HMDP_OP_WRITE, 16'h3333);
    chk("dm 3FDF", 16'h1111, dm[14'h3FDF]);
    chk("dm 3FE0", 16'h5A5A, dm[14'h3FE0]);
    chk("dm 3FE1", 16'h6B6B, dm[14'h3FE1]);
    chk("start reg", 16'h3FE2, cpu_rdata);
    op(HMDP_OP_LATCH, 16'h8005);
    chk("overlay", 8'h05, mem_overlay);
    op(HMDP_OP_LATCH, 16'hFFA3);
    chk("overlay", 8'hA3, mem_overlay);
    chk("start reg", 16'h3FE2, cpu_rdata);
  endtask

  task automatic t_cpu();
    logic [31:0] q;
    cpu_w(14'h3FE1, 16'h0300);
    chk("start reg", 16'h3FE2, cpu_rdata);
    cpu_w(14'h3FE0, 16'h0200);
    chk("start reg", 16'h0200, cpu_rdata);
    op(HMDP_OP_WRITE, 16'h7E7E);
    chk("dm 0200", 16'h7E7E, dm[14'h0200]);
    chk("start reg", 16'h0201, cpu_rdata);
    av(1'b0, 4'hC, 32'hFFFF_FFFF, q);
    av(1'b1, 4'hC, 32'h0000_0000, q);
    chk("unmapped", 32'h0000_0000, q);
    av(1'b1, HMDP_AV_STATUS, 32'h0000_0000, q);
    chk("idle busy", 1'b0, q[0]);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn          = 1'b0;
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
    s_host        = 1'b1;
    s_boot        = 1'b1;
    s_drive       = 1'b0;
    cpu_we        = 1'b0;
    cpu_addr      = 14'h0000;
    cpu_wdata     = 16'h0000;
    error_cnt     = 0;
    checked       = 0;
    dm[14'h3FE0]  = 16'h5A5A;
    dm[14'h3FE1]  = 16'h6B6B;
    do_reset(1'b1, 1'b1, 1'b0);
    t_boot();
    t_dm();
    t_ctrl();
    t_cpu();
    do_reset(1'b1, 1'b0, 1'b1);
    chk("ack_oe", 0, link.ack_oe);
    chk("exec_hold", 0, exec_hold);
    t_dm();
    do_reset(1'b0, 1'b0, 1'b0);
    chk("host_mode", 0, host_mode);
    conclude();
  end

  // the whole run needs well under a tenth of this span
  initial begin
    #200000;
    error_cnt++;
    conclude();
  end
endmodule
